// ===== hw/rapt_ctrl.sv
// controller end: AHB-Lite register slave and per-bank command spacing
// assumes a single AHB-Lite master, word transfers only, device on the link
`timescale 1ns/1ns
module rapt_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [rapt_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [rapt_pkg::DATA_W-1:0] hrdata,
  // command link
  rapt_if.ctrl link
);
  import rapt_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic addr_ph;
  logic wr_ph_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [DATA_W-1:0] hrdata_ff;
  logic [DATA_W-1:0] stat_w;
  logic [AL_W-1:0] al_ff;
  logic [AL_W-1:0] cl_ff;
  logic bl8_ff;
  logic cmd_pend_ff;
  rapt_op_t op_ff;
  logic [BANK_W-1:0] bank_ff;
  logic ap_ff;
  logic [DATA_W-1:0] rdat_ff;
  logic ok;
  logic issue;
  logic [TW-1:0] half;
  logic [TW-1:0] ap_act_load;
  logic [TW-1:0] rd_pre_load;
  logic [TW-1:0] rd_gap_ff;
  logic [TW-1:0] wr_gap_ff;
  logic [NBANK-1:0] act_free;
  logic [NBANK-1:0] pre_free;
  logic [NBANK-1:0] bank_free;
  logic cmd_valid_ff;
  rapt_op_t cmd_op_ff;
  logic [BANK_W-1:0] cmd_bank_ff;
  logic cmd_ap_ff;

  // larger of two counts
  function automatic logic [TW-1:0] tmax(input logic [TW-1:0] a, input logic [TW-1:0] b);
    tmax = (a > b) ? a : b;
  endfunction

  // ---------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ---------------------------------------------------------------
  assign addr_ph = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_ff;

  // write address held into the data phase
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ph_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      wr_ph_ff <= addr_ph && hwrite;
      if (addr_ph) begin
        wr_addr_ff <= haddr[ADDR_W-1:0];
      end
    end
  end

  // status word
  always_comb begin
    stat_w = '0;
    stat_w[STAT_PEND_BIT] = cmd_pend_ff;
    stat_w[STAT_OPEN_LSB +: NBANK] = link.bank_open;
    stat_w[STAT_PRE_LSB +: NBANK] = link.bank_precharging;
    stat_w[STAT_BLK_LSB +: NBANK] = ~act_free;
  end

  // read data registered at the address phase, unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_ff <= '0;
    end else if (addr_ph && !hwrite) begin
      if (haddr[ADDR_W-1:0] == REG_CFG) begin
        hrdata_ff <= DATA_W'({bl8_ff, 1'b0, cl_ff, 1'b0, al_ff});
      end else if (haddr[ADDR_W-1:0] == REG_CMD) begin
        hrdata_ff <= DATA_W'({ap_ff, 1'b0, bank_ff, 1'b0, op_ff});
      end else if (haddr[ADDR_W-1:0] == REG_STAT) begin
        hrdata_ff <= stat_w;
      end else if (haddr[ADDR_W-1:0] == REG_RDAT) begin
        hrdata_ff <= rdat_ff;
      end else begin
        hrdata_ff <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration and command registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      al_ff <= AL_RST;
      cl_ff <= CL_RST;
      bl8_ff <= BL8_RST;
    end else if (wr_ph_ff && (wr_addr_ff == REG_CFG)) begin
      al_ff <= hwdata[CFG_AL_LSB +: AL_W];
      cl_ff <= hwdata[CFG_CL_LSB +: AL_W];
      bl8_ff <= hwdata[CFG_BL8_BIT];
    end
  end

  // one pending command; writes while pending are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_pend_ff <= 1'b0;
      op_ff <= OP_NOP;
      bank_ff <= '0;
      ap_ff <= 1'b0;
    end else if (issue) begin
      cmd_pend_ff <= 1'b0;
    end else if (wr_ph_ff && (wr_addr_ff == REG_CMD) && !cmd_pend_ff) begin
      cmd_pend_ff <= 1'b1;
      op_ff <= rapt_op_t'(hwdata[CMD_OP_LSB +: OP_W]);
      bank_ff <= hwdata[CMD_BANK_LSB +: BANK_W];
      ap_ff <= hwdata[CMD_AP_BIT];
    end
  end

  // last returned read word
  always_ff @(posedge clk) begin
    if (srst) begin
      rdat_ff <= '0;
    end else if (link.rd_valid) begin
      rdat_ff <= link.rd_data;
    end
  end

  // ---------------------------------------------------------------
  // spacing loads
  // ---------------------------------------------------------------
  assign half = bl8_ff ? BL8_HALF : BL4_HALF;
  // activate after auto precharge: latency, burst extra, rounded sum
  assign ap_act_load = TW'(al_ff) + (bl8_ff ? BL8_EXTRA : '0) + RTPRP_CYC - ONE;
  // explicit precharge after a plain read
  assign rd_pre_load = TW'(al_ff) + half - PRE_TRIM + RTP_EFF - ONE;

  // ---------------------------------------------------------------
  // per-bank timers, activate and precharge gated only by their own bank
  // ---------------------------------------------------------------
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic mine;
    logic [TW-1:0] act_ff;
    logic [TW-1:0] pre_ff;
    logic [TW-1:0] any_ff;

    assign mine = issue && (bank_ff == BANK_W'(b));
    assign act_free[b] = (act_ff == '0);
    assign pre_free[b] = (pre_ff == '0);
    assign bank_free[b] = (any_ff == '0);

    // activate countdown
    always_ff @(posedge clk) begin
      if (srst) begin
        act_ff <= '0;
      end else if (mine && (op_ff == OP_ACT)) begin
        act_ff <= RC_CYC - ONE;
      end else if (mine && (op_ff == OP_RD) && ap_ff) begin
        act_ff <= tmax(act_ff, ap_act_load);
      end else if (mine && (op_ff == OP_PRE)) begin
        act_ff <= tmax(act_ff, RP_CYC - ONE);
      end else if (act_ff != '0) begin
        act_ff <= act_ff - ONE;
      end
    end

    // explicit precharge countdown
    always_ff @(posedge clk) begin
      if (srst) begin
        pre_ff <= '0;
      end else if (mine && (op_ff == OP_RD) && !ap_ff) begin
        pre_ff <= tmax(pre_ff, rd_pre_load);
      end else if (pre_ff != '0) begin
        pre_ff <= pre_ff - ONE;
      end
    end

    // whole-bank block during an explicit precharge period
    always_ff @(posedge clk) begin
      if (srst) begin
        any_ff <= '0;
      end else if (mine && (op_ff == OP_PRE)) begin
        any_ff <= RP_CYC - ONE;
      end else if (any_ff != '0) begin
        any_ff <= any_ff - ONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // spacing to any bank after a read
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_gap_ff <= '0;
      wr_gap_ff <= '0;
    end else if (issue && (op_ff == OP_RD)) begin
      rd_gap_ff <= half - ONE;
      wr_gap_ff <= half + WR_EXTRA - ONE;
    end else begin
      if (rd_gap_ff != '0) begin
        rd_gap_ff <= rd_gap_ff - ONE;
      end
      if (wr_gap_ff != '0) begin
        wr_gap_ff <= wr_gap_ff - ONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // issue decision
  // ---------------------------------------------------------------
  // precharge or activate elsewhere needs only the next clock
  always_comb begin
    ok = 1'b0;
    case (op_ff)
      OP_ACT: ok = act_free[bank_ff] && bank_free[bank_ff];
      OP_PRE: ok = pre_free[bank_ff] && bank_free[bank_ff];
      OP_RD: ok = (rd_gap_ff == '0) && bank_free[bank_ff];
      OP_WR: ok = (wr_gap_ff == '0) && bank_free[bank_ff];
      default: ok = 1'b1;
    endcase
  end

  assign issue = cmd_pend_ff && ok;

  // link drive, one cycle per command
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_valid_ff <= 1'b0;
      cmd_op_ff <= OP_NOP;
      cmd_bank_ff <= '0;
      cmd_ap_ff <= 1'b0;
    end else begin
      cmd_valid_ff <= issue;
      cmd_op_ff <= issue ? op_ff : OP_NOP;
      cmd_bank_ff <= issue ? bank_ff : '0;
      cmd_ap_ff <= issue && ap_ff;
    end
  end

  assign link.cmd_valid = cmd_valid_ff;
  assign link.cmd_op = cmd_op_ff;
  assign link.cmd_bank = cmd_bank_ff;
  assign link.autoprecharge_address_bit = cmd_ap_ff;
  assign link.additive_latency = al_ff;
  assign link.cas_latency = cl_ff;
  assign link.burst_length_8 = bl8_ff;
endmodule

// ===== hw/rapt_pkg.sv
// shared constants, types and timing counts for the read auto precharge pair
// assumes both ends run on one 100 MHz clock with a synchronous active-high reset
// Contract
// - high precharge address bit selects auto precharge
// - precharge starts additive latency plus half burst
// - precharge waits for row active minimum
// - precharge waits read-to-precharge; period counts from start
// - burst four: activate after latency plus rounded sum
// - burst eight: activate after latency, two, sum
// - read-to-precharge plus precharge period rounded up
// - precharge never before two clocks after prefetch
// - other banks keep working during auto precharge
// - read to other bank waits half burst
// - write to other bank waits half plus two
// - precharge or activate elsewhere waits one clock
// - explicit precharge spacing after plain read
// - first read data after additive plus cas
// - nothing to bank during precharge period; the controller blocks the whole bank only after an explicit precharge
package rapt_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int NBANK = 8;
  localparam int BANK_W = 3;
  localparam int AL_W = 3;
  localparam int RL_W = 4;
  localparam int TW = 6;
  localparam int OP_W = 3;
  localparam int BEAT_W = 4;
  localparam int PIPE_D = 16;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // ---------------------------------------------------------------
  // timing in picoseconds and derived clock counts
  // ---------------------------------------------------------------
  localparam int CLK_PS = 10000;
  localparam int RAS_MIN_PS = 40000;
  localparam int RTP_PS = 7500;
  localparam int RP_PS = 15000;
  localparam int RC_PS = 55000;
  localparam logic [TW-1:0] RAS_CYC = TW'((RAS_MIN_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [TW-1:0] RTP_CYC = TW'((RTP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [TW-1:0] RP_CYC = TW'((RP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [TW-1:0] RC_CYC = TW'((RC_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [TW-1:0] RTPRP_CYC = TW'((RTP_PS + RP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [TW-1:0] RTP_FLOOR = 6'h02;
  localparam logic [TW-1:0] RTP_EFF = (RTP_CYC > RTP_FLOOR) ? RTP_CYC : RTP_FLOOR;

  // ---------------------------------------------------------------
  // burst figures
  // ---------------------------------------------------------------
  localparam logic [TW-1:0] BL4_HALF = 6'h02;
  localparam logic [TW-1:0] BL8_HALF = 6'h04;
  localparam logic [TW-1:0] BL8_EXTRA = 6'h02;
  localparam logic [TW-1:0] WR_EXTRA = 6'h02;
  localparam logic [TW-1:0] PRE_TRIM = 6'h02;
  localparam logic [TW-1:0] ONE = 6'h01;
  localparam logic [RL_W-1:0] RL_TRIM = 4'h2;

  // ---------------------------------------------------------------
  // controller register map and fields
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RDAT = 8'h0C;
  localparam int CFG_AL_LSB = 0;
  localparam int CFG_CL_LSB = 4;
  localparam int CFG_BL8_BIT = 8;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_AP_BIT = 8;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_OPEN_LSB = 8;
  localparam int STAT_PRE_LSB = 16;
  localparam int STAT_BLK_LSB = 24;
  localparam logic [AL_W-1:0] AL_RST = 3'h0;
  localparam logic [AL_W-1:0] CL_RST = 3'h3;
  localparam logic BL8_RST = 1'b0;
  localparam logic HRESP_OKAY = 1'b0;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  typedef enum logic [OP_W-1:0] {
    OP_NOP = 3'b000,
    OP_ACT = 3'b001,
    OP_RD  = 3'b010,
    OP_WR  = 3'b011,
    OP_PRE = 3'b100
  } rapt_op_t;

endpackage

// ===== hw/rapt_if.sv
// command link between controller and memory device
// assumes both ends sample it on the same clk edge
`timescale 1ns/1ns
interface rapt_if;
  import rapt_pkg::*;
  logic cmd_valid;
  rapt_op_t cmd_op;
  logic [BANK_W-1:0] cmd_bank;
  logic autoprecharge_address_bit;
  logic [AL_W-1:0] additive_latency;
  logic [AL_W-1:0] cas_latency;
  logic burst_length_8;
  logic rd_valid;
  logic [DATA_W-1:0] rd_data;
  logic [NBANK-1:0] bank_open;
  logic [NBANK-1:0] bank_precharging;

  modport ctrl (
    output cmd_valid, cmd_op, cmd_bank, autoprecharge_address_bit,
    output additive_latency, cas_latency, burst_length_8,
    input rd_valid, rd_data, bank_open, bank_precharging
  );
  modport mem (
    input cmd_valid, cmd_op, cmd_bank, autoprecharge_address_bit,
    input additive_latency, cas_latency, burst_length_8,
    output rd_valid, rd_data, bank_open, bank_precharging
  );
endinterface

// ===== hw/rapt_dev.sv
// memory device end: bank state, auto precharge scheduling, read data return
// assumes the controller keeps the command spacing it owes
`timescale 1ns/1ns
module rapt_dev (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // command link
  rapt_if.mem link,
  // precharge events and read latency
  output logic [rapt_pkg::NBANK-1:0] pre_start,
  output logic [rapt_pkg::RL_W-1:0] read_latency
);
  import rapt_pkg::*;

  // ---------------------------------------------------------------
  // shared decode and load values
  // ---------------------------------------------------------------
  logic [TW-1:0] half;
  logic [TW-1:0] sched_load;
  logic [TW-1:0] rtp_load;
  logic rd_cmd;
  logic [PIPE_D-1:0] pipe_ff;
  logic [BANK_W-1:0] bpipe_ff [PIPE_D];
  logic [BEAT_W-1:0] left_ff;
  logic [BEAT_W-1:0] beat_ff;
  logic [BANK_W-1:0] cur_bank_ff;
  logic rd_valid_ff;
  logic [DATA_W-1:0] rd_data_ff;

  assign half = link.burst_length_8 ? BL8_HALF : BL4_HALF;
  assign rd_cmd = link.cmd_valid && (link.cmd_op == OP_RD);
  // scheduled edge sits additive latency plus half burst out
  assign sched_load = TW'(link.additive_latency) + half - ONE;
  // last prefetch plus the larger of read-to-precharge and two clocks
  assign rtp_load = TW'(link.additive_latency) + (link.burst_length_8 ? BL8_EXTRA : '0)
                    + RTP_EFF - ONE;
  assign read_latency = RL_W'(link.additive_latency) + RL_W'(link.cas_latency);

  // ---------------------------------------------------------------
  // per-bank state, banks run independently
  // ---------------------------------------------------------------
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic hit;
    logic start;
    logic pend_ff;
    logic open_ff;
    logic [TW-1:0] ras_ff;
    logic [TW-1:0] sched_ff;
    logic [TW-1:0] rtp_ff;
    logic [TW-1:0] rp_ff;

    assign hit = link.cmd_valid && (link.cmd_bank == BANK_W'(b));
    // start only when schedule, read-to-precharge and row active are all met
    assign start = pend_ff && (sched_ff == '0) && (rtp_ff == '0) && (ras_ff >= RAS_CYC);
    assign pre_start[b] = start;
    assign link.bank_open[b] = open_ff;
    assign link.bank_precharging[b] = (rp_ff != '0);

    // row active time since activate, saturating
    always_ff @(posedge clk) begin
      if (srst) begin
        ras_ff <= '0;
      end else if (hit && (link.cmd_op == OP_ACT)) begin
        ras_ff <= ONE;
      end else if (ras_ff < RAS_CYC) begin
        ras_ff <= ras_ff + ONE;
      end
    end

    // auto precharge request and its two countdowns
    always_ff @(posedge clk) begin
      if (srst) begin
        pend_ff <= 1'b0;
        sched_ff <= '0;
        rtp_ff <= '0;
      end else if (hit && (link.cmd_op == OP_RD) && link.autoprecharge_address_bit) begin
        pend_ff <= 1'b1;
        sched_ff <= sched_load;
        rtp_ff <= rtp_load;
      end else begin
        if (start) begin
          pend_ff <= 1'b0;
        end
        if (sched_ff != '0) begin
          sched_ff <= sched_ff - ONE;
        end
        if (rtp_ff != '0) begin
          rtp_ff <= rtp_ff - ONE;
        end
      end
    end

    // precharge period counted from the real start point
    always_ff @(posedge clk) begin
      if (srst) begin
        rp_ff <= '0;
        open_ff <= 1'b0;
      end else if (start || (hit && (link.cmd_op == OP_PRE))) begin
        rp_ff <= RP_CYC;
        open_ff <= 1'b0;
      end else begin
        if (hit && (link.cmd_op == OP_ACT)) begin
          open_ff <= 1'b1;
        end
        if (rp_ff != '0) begin
          rp_ff <= rp_ff - ONE;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read latency pipe, one word per clock for half the burst
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pipe_ff <= '0;
    end else begin
      pipe_ff <= (pipe_ff >> 1) | (rd_cmd ? (PIPE_D'(1) << (read_latency - RL_TRIM)) : '0);
    end
  end

  // bank of each read travels beside its pipe slot
  always_ff @(posedge clk) begin
    for (int i = 0; i < PIPE_D; i++) begin
      if (srst) begin
        bpipe_ff[i] <= '0;
      end else if (rd_cmd && (RL_W'(i) == read_latency - RL_TRIM)) begin
        bpipe_ff[i] <= link.cmd_bank;
      end else begin
        bpipe_ff[i] <= (i == PIPE_D - 1) ? '0 : bpipe_ff[(i + 1) % PIPE_D];
      end
    end
  end

  // data beats: bank and beat index in the low bits
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_valid_ff <= 1'b0;
      left_ff <= '0;
      beat_ff <= '0;
      cur_bank_ff <= '0;
      rd_data_ff <= '0;
    end else if (pipe_ff[0]) begin
      rd_valid_ff <= 1'b1;
      left_ff <= BEAT_W'(half - ONE);
      beat_ff <= '0;
      cur_bank_ff <= bpipe_ff[0];
      rd_data_ff <= {{(DATA_W - BANK_W - BEAT_W){1'b0}}, bpipe_ff[0], {BEAT_W{1'b0}}};
    end else if (left_ff != '0) begin
      rd_valid_ff <= 1'b1;
      left_ff <= left_ff - 1'b1;
      beat_ff <= beat_ff + 1'b1;
      rd_data_ff <= {{(DATA_W - BANK_W - BEAT_W){1'b0}}, cur_bank_ff, beat_ff + 1'b1};
    end else begin
      rd_valid_ff <= 1'b0;
    end
  end

  assign link.rd_valid = rd_valid_ff;
  assign link.rd_data = rd_data_ff;
endmodule

// ===== dv/rapt_properties.sv
// concurrent checks on the command link between controller and device
// assumes instantiation beside the link interface, one clock, sync reset
`timescale 1ns/1ns
module rapt_properties (
  // clock and reset
  input logic clk,
  input logic srst,
  // command side
  input logic cmd_valid,
  input rapt_pkg::rapt_op_t cmd_op,
  input logic [rapt_pkg::BANK_W-1:0] cmd_bank,
  input logic autoprecharge_address_bit,
  input logic [rapt_pkg::AL_W-1:0] additive_latency,
  input logic [rapt_pkg::AL_W-1:0] cas_latency,
  input logic burst_length_8,
  // device side
  input logic rd_valid,
  input logic [rapt_pkg::DATA_W-1:0] rd_data,
  input logic [rapt_pkg::NBANK-1:0] bank_open,
  input logic [rapt_pkg::NBANK-1:0] bank_precharging
);
  import rapt_pkg::*;
  logic [TW-1:0] half, al6, rd_age_ff, ap_age_ff;
  logic [BANK_W-1:0] rd_bank_ff, ap_bank_ff;
  logic rd_ap_ff, rd_now, ap_rise;
  logic [TW-1:0] act_age_ff [NBANK];

  // decoded link config
  assign al6 = TW'(additive_latency);
  assign half = burst_length_8 ? BL8_HALF : BL4_HALF;
  assign rd_now = cmd_valid && cmd_op == OP_RD;

  // cycles since the last read of any kind, saturating
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_age_ff <= '1;
      rd_bank_ff <= '0;
      rd_ap_ff <= 1'b0;
    end else if (rd_now) begin
      rd_age_ff <= ONE;
      rd_bank_ff <= cmd_bank;
      rd_ap_ff <= autoprecharge_address_bit;
    end else if (rd_age_ff != '1) begin
      rd_age_ff <= rd_age_ff + ONE;
    end
  end

  // cycles since the last auto precharge read
  always_ff @(posedge clk) begin
    if (srst) begin
      ap_age_ff <= '1;
      ap_bank_ff <= '0;
    end else if (rd_now && autoprecharge_address_bit) begin
      ap_age_ff <= ONE;
      ap_bank_ff <= cmd_bank;
    end else if (ap_age_ff != '1) begin
      ap_age_ff <= ap_age_ff + ONE;
    end
  end

  // cycles since each bank was last activated
  always_ff @(posedge clk) begin
    for (int b = 0; b < NBANK; b++) begin
      if (srst)
        act_age_ff[b] <= '1;
      else if (cmd_valid && cmd_op == OP_ACT && cmd_bank == BANK_W'(b))
        act_age_ff[b] <= ONE;
      else if (act_age_ff[b] != '1)
        act_age_ff[b] <= act_age_ff[b] + ONE;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  AST_AP_CLOSES: assert property (
    rd_now && autoprecharge_address_bit |=> ##[1:12] bank_precharging[ap_bank_ff])
    else $error("auto precharge did not start in time");
  AST_AP_NOT_EARLY: assert property (
    $rose(bank_precharging[ap_bank_ff]) && ap_age_ff < 6'h10 |-> ap_age_ff > al6 + half)
    else $error("auto precharge started too early");
  AST_AP_RAS: assert property (
    $rose(bank_precharging[ap_bank_ff]) && ap_age_ff < 6'h10 |-> act_age_ff[ap_bank_ff] > RAS_CYC)
    else $error("auto precharge started before row active minimum");
  AST_PRE_PERIOD: assert property (
    $rose(bank_precharging[ap_bank_ff]) |->
      bank_precharging[ap_bank_ff][*2] ##1 !bank_precharging[ap_bank_ff])
    else $error("precharge period length wrong");
  AST_ACT_AFTER_AP: assert property (
    cmd_valid && cmd_op == OP_ACT && cmd_bank == ap_bank_ff |->
      ap_age_ff >= al6 + (burst_length_8 ? BL8_EXTRA : 6'h00) + RTPRP_CYC)
    else $error("activate too soon after auto precharge read");
  AST_ACT_ROW_CYCLE: assert property (
    cmd_valid && cmd_op == OP_ACT |-> act_age_ff[cmd_bank] >= RC_CYC)
    else $error("activate too soon after activate");
  AST_RD_GAP: assert property (
    rd_now |-> rd_age_ff >= half)
    else $error("read too soon after read");
  AST_WR_GAP: assert property (
    cmd_valid && cmd_op == OP_WR |-> rd_age_ff >= half + WR_EXTRA)
    else $error("write too soon after read");
  AST_PRE_AFTER_RD: assert property (
    cmd_valid && cmd_op == OP_PRE && cmd_bank == rd_bank_ff && !rd_ap_ff |->
      rd_age_ff >= al6 + half - PRE_TRIM + RTP_EFF)
    else $error("precharge too soon after read");
  AST_RL_BL4: assert property (
    rd_now && additive_latency == 3'h0 && cas_latency == 3'h3 && !burst_length_8 |->
      ##3 (rd_valid && rd_data[3:0] == 4'h0) ##1 (rd_valid && rd_data[3:0] == 4'h1))
    else $error("burst four read data timing wrong");
  AST_RL_BL8: assert property (
    rd_now && additive_latency == 3'h1 && cas_latency == 3'h3 && burst_length_8 |->
      ##4 (rd_valid && rd_data[3:0] == 4'h0) ##1 rd_valid[*3])
    else $error("burst eight read data timing wrong");
endmodule

// ===== dv/rapt_tb_top.sv
// self-checking bench: controller and device joined by the link interface
// assumes AHB-Lite register access to the controller, one 100 MHz clock
`timescale 1ns/1ns
module rapt_tb_top;
  import rapt_pkg::*;
  logic clk, srst, hsel, hwrite, hready, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr;
  logic [DATA_W-1:0] hwdata, hrdata, rv;
  logic [NBANK-1:0] pre_start;
  logic [RL_W-1:0] read_latency;
  int bad_count, n_checks, cyc, rd_cyc, c0, c1, c2, c3;
  int pre_cyc [NBANK];

  rapt_if rapt_if_i ();
  rapt_ctrl rapt_ctrl_i (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .link(rapt_if_i.ctrl));
  rapt_dev rapt_dev_i (.clk(clk), .srst(srst), .link(rapt_if_i.mem), .pre_start(pre_start),
    .read_latency(read_latency));
  rapt_properties rapt_properties_i (.clk(clk), .srst(srst), .cmd_valid(rapt_if_i.cmd_valid),
    .cmd_op(rapt_if_i.cmd_op), .cmd_bank(rapt_if_i.cmd_bank),
    .autoprecharge_address_bit(rapt_if_i.autoprecharge_address_bit),
    .additive_latency(rapt_if_i.additive_latency), .cas_latency(rapt_if_i.cas_latency),
    .burst_length_8(rapt_if_i.burst_length_8), .rd_valid(rapt_if_i.rd_valid),
    .rd_data(rapt_if_i.rd_data), .bank_open(rapt_if_i.bank_open),
    .bank_precharging(rapt_if_i.bank_precharging));

  // ---------------------------------------------------------------
  // clock, link monitor and hang limit
  // ---------------------------------------------------------------
  always #5 clk = ~clk;

  // records precharge start and first beat cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int b = 0; b < NBANK; b++) begin
      if (pre_start[b] === 1'b1)
        pre_cyc[b] = cyc;
    end
    if (rapt_if_i.rd_valid === 1'b1 && rapt_if_i.rd_data[3:0] === 4'h0)
      rd_cyc = cyc;
    if (cyc > 5000) begin
      bad_count++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one AHB-Lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  // queue one command and return its link cycle
  task automatic issue(input rapt_op_t op, input int bank, input logic ap, output int c);
    bus(1'b1, REG_CMD, {23'h00_0000, ap, 1'b0, 3'(bank), 1'b0, op}, rv);
    do @(posedge clk); while (rapt_if_i.cmd_valid !== 1'b1);
    c = cyc;
  endtask

  // activate, auto precharge read, activate again on one bank
  task automatic run_ap(input int al, input logic bl8, input int bank);
    int half, ca, cr, cn, e;
    half = bl8 ? 4 : 2;
    bus(1'b1, REG_CFG, {23'h00_0000, bl8, 1'b0, 3'h3, 1'b0, 3'(al)}, rv);
    issue(OP_ACT, bank, 1'b0, ca);
    issue(OP_RD, bank, 1'b1, cr);
    issue(OP_ACT, bank, 1'b0, cn);
    e = al + half;
    if (ca + 4 - cr > e)
      e = ca + 4 - cr;
    check("precharge start", pre_cyc[bank] - cr, e);
    check("activate gap", 32'(cn - cr >= al + (bl8 ? 2 : 0) + 3), 1);
    check("row cycle", 32'(cn - ca >= 6), 1);
    repeat (al + 3 + half) @(posedge clk);
    check("first beat", rd_cyc - cr, al + 3);
    check("read latency", read_latency, al + 3);
    bus(1'b0, REG_RDAT, '0, rv);
    check("last beat", rv, 32'(bank * 16 + half - 1));
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    bad_count = 0;
    n_checks = 0;
    cyc = 0;
    foreach (pre_cyc[b]) pre_cyc[b] = -1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // reset values and response
    bus(1'b0, REG_CFG, '0, rv);
    check("cfg reset", rv, 32'h0000_0030);
    bus(1'b0, REG_STAT, '0, rv);
    check("status reset", rv, 32'h0000_0000);
    bus(1'b0, 8'h10, '0, rv);
    check("unmapped read", rv, 32'h0000_0000);
    check("response", {31'h0000_0000, hresp}, 32'h0000_0000);
    // burst four without added latency, then burst eight with one
    run_ap(0, 1'b0, 1);
    run_ap(1, 1'b1, 2);
    // other banks around an auto precharge
    issue(OP_ACT, 3, 1'b0, c0);
    issue(OP_ACT, 4, 1'b0, c0);
    issue(OP_RD, 3, 1'b1, c0);
    issue(OP_RD, 4, 1'b0, c1);
    check("read gap", 32'(c1 - c0 >= 4), 1);
    issue(OP_WR, 4, 1'b0, c2);
    check("write gap", 32'(c2 - c1 >= 6), 1);
    check("plain read keeps row", pre_cyc[4], 32'hFFFF_FFFF);
    issue(OP_PRE, 4, 1'b0, c3);
    check("precharge gap", 32'(c3 - c1 >= 5), 1);
    repeat (8) @(posedge clk);
    bus(1'b0, REG_STAT, '0, rv);
    check("open banks", rv[15:8], 8'h06);
    check("precharging banks", rv[23:16], 8'h00);
    stop_test();
  end
endmodule
